// [verilog/besl_map.svh]
// Offsets, bit positions, reset values and timing counts of the bus error status logger
`ifndef BESL_MAP_SVH
`define BESL_MAP_SVH

// Register offsets inside the node space
`define BESL_OFF_STATUS 8'h04
`define BESL_OFF_FADR 8'h08
`define BESL_OFF_EXT 8'h14
`define BESL_OFF_FAER 8'h2C

// Bit positions in bus_error_status, and of the lock flag in the extension register
`define BESL_ES 31
`define BESL_NODE_RESET_CMD 30
`define BESL_NODE_HALT_CMD 29
`define BESL_BAD 28
`define BESL_CC 27
`define BESL_WEI 25
`define BESL_IPE 24
`define BESL_PE 23
`define BESL_WSE 22
`define BESL_READ_DATA_NOACK 21
`define BESL_WRITE_DATA_NOACK 20
`define BESL_CRD 19
`define BESL_NRR 18
`define BESL_RSE 17
`define BESL_RER 16
`define BESL_COMMAND_NOACK 15
`define BESL_TTO 13
`define BESL_NODE_SPECIFIC_SUMMARY 12
`define BESL_ETF 11
`define BESL_STF 10
`define BESL_FAILING_MASTER_ID_LSB 4
`define BESL_FAILING_MASTER_ID_MSB 9
`define BESL_EXT_LOCK 1

// Field masks and reset values
`define BESL_W1C_MASK 32'h0BFFAC00
`define BESL_LOCK_MASK 32'h0017A000
`define BESL_W1C_RESET 32'h00000C00
`define BESL_EXT_MASK 32'h00000002

// Timing: times in their own unit, counts derived from the clock period
`define BESL_CLK_PERIOD_NS 40
`define BESL_TXN_TIMEOUT_NS 16000000
`define BESL_TXN_TIMEOUT_CYC (`BESL_TXN_TIMEOUT_NS / `BESL_CLK_PERIOD_NS)
`define BESL_SELFTEST_MAX_US 10000
`define BESL_SELFTEST_MAX_CYC ((`BESL_SELFTEST_MAX_US * 1000) / `BESL_CLK_PERIOD_NS)

`endif

// [verilog/besl_pkg.sv]
// Types shared by the bus error status logger
`default_nettype none
package besl_pkg;

  typedef enum logic [0:0] {
    BESL_ST_RUN,
    BESL_ST_SELFTEST
  } besl_state_t;

  typedef struct packed {
    besl_state_t state;
    logic [23:0] st_cnt;
    logic node_reset_cmd;
    logic node_halt_cmd;
    logic bad_drv;
    logic [31:0] ber_w1c;
    logic [31:0] ext_w1c;
    logic [31:0] fadr;
    logic [31:0] faer;
    logic txn_busy;
    logic [19:0] txn_cnt;
    logic [31:0] rdata;
    logic rvalid;
    logic halt_req;
    logic hard_irq;
    logic bad_oe;
    logic bad_o;
    logic node_busy;
    logic dc_s1;
    logic dc_s2;
    logic bad_s1;
    logic bad_s2;
    logic hen_s1;
    logic hen_s2;
    logic [3:0] id_s1;
    logic [3:0] id_s2;
  } besl_regs_t;

endpackage
`default_nettype wire

// [verilog/besl_logger.sv]
// Bus error status register, failing address logging and node reset control
`timescale 1ns/10ps
`default_nettype none
`include "besl_map.svh"

// What this block does
// - Summary bit is OR of all error flags
// - Node reset command reruns self-test, holds bad line
// - Power-up clears node reset bit; node reset keeps it
// - Halt command halts processor while halts enabled
// - Bad line bit reads wired line, drives contribution
// - Corrected confirmation error sets its flag
// - Write error vector sets flag and hard interrupt
// - Parity error with ACK sets inconsistent parity
// - Any bus parity error sets parity flag
// - Aborted own register write sets sequence flag
// - No-acked read data cycle sets its flag
// - Failed write data sets flag, timeout with retry
// - Corrected read response sets its flag
// - Missing read reply sets flag and timeout
// - Read sequence number mismatch sets its flag
// - Read error response sets its flag
// - Finally no-acked command sets its flag
// - Transaction timer expiry sets timeout flag
// - Node-specific summary is OR of extension flags
// - Test fail flags reset set, firmware clears them
// - Failing master id returns own slot number
// - Log address unless locking flags are set
module besl_logger
  import besl_pkg::*;
#(
  parameter int unsigned TXN_TIMEOUT_CYC = `BESL_TXN_TIMEOUT_CYC,
  parameter int unsigned SELFTEST_MAX_CYC = `BESL_SELFTEST_MAX_CYC
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic dc_low_line_n,
  input wire logic node_bad_line_in_n,
  input wire logic halt_enable,
  input wire logic [3:0] slot_id,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic selftest_pass,
  input wire logic txn_req,
  input wire logic txn_end,
  input wire logic txn_start,
  input wire logic [31:0] txn_cmd_addr,
  input wire logic [31:0] txn_ext_info,
  input wire logic ev_cnf_single,
  input wire logic ev_wei_implied_vector_intr,
  input wire logic ev_parity_err,
  input wire logic ev_cnf_ack,
  input wire logic ev_csr_write_abort,
  input wire logic ev_read_data_noack,
  input wire logic ev_write_noack_final,
  input wire logic retry_enable,
  input wire logic ev_crd_resp,
  input wire logic ev_no_read_reply,
  input wire logic seq_valid,
  input wire logic [3:0] seq_rx,
  input wire logic [3:0] seq_exp,
  input wire logic ev_read_err_resp,
  input wire logic ev_cmd_noack_final,
  input wire logic ev_ext_lock,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic node_bad_line_o,
  output logic node_bad_line_oe,
  output logic node_busy,
  output logic halt_request,
  output logic hard_err_irq
);

  localparam besl_regs_t BESL_INIT = '{
    state: BESL_ST_SELFTEST,
    bad_drv: 1'b1,
    ber_w1c: `BESL_W1C_RESET,
    bad_oe: 1'b1,
    node_busy: 1'b1,
    default: '0
  };

  besl_regs_t s;
  besl_regs_t next_s;
  logic reinit;
  logic es_now;
  logic node_specific_summary_now;
  logic locked;
  logic [31:0] status_view;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] ext_set;
  logic [31:0] ext_clr;
  logic wr_status;
  logic wr_ext;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    next_s = s;
    wr_status = reg_wr && (reg_addr == `BESL_OFF_STATUS);
    wr_ext = reg_wr && (reg_addr == `BESL_OFF_EXT);
    node_specific_summary_now = |(s.ext_w1c & `BESL_EXT_MASK);
    es_now = (|(s.ber_w1c & `BESL_W1C_MASK)) | node_specific_summary_now;
    locked = (|(s.ber_w1c & `BESL_LOCK_MASK)) | s.ext_w1c[`BESL_EXT_LOCK];

    status_view = '0;
    status_view = s.ber_w1c & `BESL_W1C_MASK;
    status_view[`BESL_ES] = es_now;
    status_view[`BESL_NODE_RESET_CMD] = s.node_reset_cmd;
    status_view[`BESL_NODE_HALT_CMD] = s.node_halt_cmd;
    status_view[`BESL_BAD] = ~s.bad_s2;
    status_view[`BESL_NODE_SPECIFIC_SUMMARY] = node_specific_summary_now;
    status_view[`BESL_FAILING_MASTER_ID_MSB:`BESL_FAILING_MASTER_ID_LSB] = {2'h0, s.id_s2};

    // Hardware events; each set outranks a clear in the same cycle
    set_vec = '0;
    set_vec[`BESL_CC] = ev_cnf_single;
    set_vec[`BESL_WEI] = ev_wei_implied_vector_intr;
    set_vec[`BESL_IPE] = ev_parity_err && ev_cnf_ack;
    set_vec[`BESL_PE] = ev_parity_err;
    set_vec[`BESL_WSE] = ev_csr_write_abort;
    set_vec[`BESL_READ_DATA_NOACK] = ev_read_data_noack;
    set_vec[`BESL_WRITE_DATA_NOACK] = ev_write_noack_final;
    set_vec[`BESL_CRD] = ev_crd_resp;
    set_vec[`BESL_NRR] = ev_no_read_reply;
    set_vec[`BESL_RSE] = seq_valid && (seq_rx != seq_exp);
    set_vec[`BESL_RER] = ev_read_err_resp;
    set_vec[`BESL_COMMAND_NOACK] = ev_cmd_noack_final;
    set_vec[`BESL_TTO] = ev_no_read_reply
      || (ev_write_noack_final && retry_enable)
      || (s.txn_busy && (s.txn_cnt == 20'(TXN_TIMEOUT_CYC - 1)));
    clr_vec = wr_status ? (reg_wdata & `BESL_W1C_MASK) : '0;
    ext_set = '0;
    ext_set[`BESL_EXT_LOCK] = ev_ext_lock;
    ext_clr = wr_ext ? (reg_wdata & `BESL_EXT_MASK) : '0;

    for (int i = 0; i < 32; i++)
    begin
      next_s.ber_w1c[i] = set_vec[i] | (s.ber_w1c[i] & ~clr_vec[i]);
      next_s.ext_w1c[i] = ext_set[i] | (s.ext_w1c[i] & ~ext_clr[i]);
    end

    if (wr_status)
    begin
      next_s.node_halt_cmd = reg_wdata[`BESL_NODE_HALT_CMD];
      next_s.bad_drv = reg_wdata[`BESL_BAD];
    end

    // Transaction timer runs from bus request to end of transaction
    if (txn_req)
    begin
      next_s.txn_busy = 1'b1;
      next_s.txn_cnt = '0;
    end
    else if (txn_end || (s.txn_busy && (s.txn_cnt == 20'(TXN_TIMEOUT_CYC - 1))))
    begin
      next_s.txn_busy = 1'b0;
    end
    else if (s.txn_busy)
    begin
      next_s.txn_cnt = s.txn_cnt + 20'h00001;
    end

    // Locking checks the flags as they stand when the transaction begins
    if (txn_start && !locked)
    begin
      next_s.fadr = txn_cmd_addr;
      next_s.faer = txn_ext_info;
    end

    unique case (s.state)
      BESL_ST_RUN:
      begin
        next_s.st_cnt = '0;
      end
      BESL_ST_SELFTEST:
      begin
        next_s.st_cnt = s.st_cnt + 24'h000001;
        if (selftest_pass || (s.st_cnt == 24'(SELFTEST_MAX_CYC - 1)))
        begin
          next_s.state = BESL_ST_RUN;
        end
      end
    endcase

    next_s.rvalid = reg_rd;
    next_s.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `BESL_OFF_STATUS: next_s.rdata = status_view;
        `BESL_OFF_FADR: next_s.rdata = s.fadr;
        `BESL_OFF_FAER: next_s.rdata = s.faer;
        `BESL_OFF_EXT: next_s.rdata = s.ext_w1c & `BESL_EXT_MASK;
        default: next_s.rdata = '0;
      endcase
    end

    next_s.halt_req = s.node_halt_cmd && s.hen_s2;
    next_s.hard_irq = ev_wei_implied_vector_intr;

    // Node reset re-runs the power-up sequence but keeps its own bit set
    reinit = !s.dc_s2 || (wr_status && reg_wdata[`BESL_NODE_RESET_CMD]);
    if (reinit)
    begin
      next_s = BESL_INIT;
      next_s.node_reset_cmd = s.dc_s2;
      next_s.rvalid = reg_rd;
    end

    // Self-test keeps the bad line asserted and blocks outgoing accesses
    next_s.node_busy = (next_s.state == BESL_ST_SELFTEST);
    next_s.bad_oe = next_s.bad_drv || next_s.node_busy;
    next_s.bad_o = 1'b0;

    // Synchronisers for pins
    next_s.dc_s1 = dc_low_line_n;
    next_s.dc_s2 = s.dc_s1;
    next_s.bad_s1 = node_bad_line_in_n;
    next_s.bad_s2 = s.bad_s1;
    next_s.hen_s1 = halt_enable;
    next_s.hen_s2 = s.hen_s1;
    next_s.id_s1 = slot_id;
    next_s.id_s2 = s.id_s1;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= BESL_INIT;
      // Line levels settle as if idle so reset is not mistaken for power-up
      s.dc_s1 <= 1'b1;
      s.dc_s2 <= 1'b1;
      s.bad_s1 <= 1'b1;
      s.bad_s2 <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign node_bad_line_o = s.bad_o;
  assign node_bad_line_oe = s.bad_oe;
  assign node_busy = s.node_busy;
  assign halt_request = s.halt_req;
  assign hard_err_irq = s.hard_irq;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_node_reset_cmd_write;
    wr_status && reg_wdata[`BESL_NODE_RESET_CMD] && s.dc_s2;
  endsequence

  sequence s_selftest_held;
    node_busy && node_bad_line_oe && s.node_reset_cmd;
  endsequence

  property p_es_read;
    reg_rd && (reg_addr == `BESL_OFF_STATUS) && !reinit
      |=> reg_rvalid && (reg_rdata[`BESL_ES] == $past(es_now));
  endproperty
  a_es_read: assert property (p_es_read) else $error("summary bit wrong");

  property p_node_reset_cmd;
    s_node_reset_cmd_write |=> s_selftest_held ##1 (s.node_reset_cmd || !s.dc_s2);
  endproperty
  a_node_reset_cmd: assert property (p_node_reset_cmd) else $error("node reset not entered");

  property p_powerup;
    !s.dc_s2 |=> !s.node_reset_cmd && node_busy && s.ber_w1c[`BESL_STF] && s.ber_w1c[`BESL_ETF];
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up state wrong");

  property p_halt;
    s.node_halt_cmd && s.hen_s2 && !reinit |=> halt_request;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not requested");

  property p_bad_drive;
    wr_status && reg_wdata[`BESL_BAD] && !reinit |=> ##1 node_bad_line_oe;
  endproperty
  a_bad_drive: assert property (p_bad_drive) else $error("bad line not driven");

  property p_ipe;
    ev_parity_err && ev_cnf_ack && !reinit
      |=> s.ber_w1c[`BESL_IPE] && s.ber_w1c[`BESL_PE];
  endproperty
  a_ipe: assert property (p_ipe) else $error("parity flags not set");

  property p_wei;
    ev_wei_implied_vector_intr && !reinit |=> hard_err_irq && s.ber_w1c[`BESL_WEI];
  endproperty
  a_wei: assert property (p_wei) else $error("write error interrupt missed");

  property p_nrr;
    ev_no_read_reply && !reinit |=> s.ber_w1c[`BESL_NRR] && s.ber_w1c[`BESL_TTO];
  endproperty
  a_nrr: assert property (p_nrr) else $error("read reply flags not set");

  property p_capture;
    txn_start && !locked && !reinit |=> s.fadr == $past(txn_cmd_addr);
  endproperty
  a_capture: assert property (p_capture) else $error("address not logged");

  property p_lock;
    txn_start && locked && !reinit |=> $stable(s.fadr) && $stable(s.faer);
  endproperty
  a_lock: assert property (p_lock) else $error("locked log changed");

  property p_sticky;
    s.ber_w1c[`BESL_PE] && !reinit && !(wr_status && reg_wdata[`BESL_PE])
      |=> s.ber_w1c[`BESL_PE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

endmodule
`default_nettype wire

// [tb/besl_far_nodes.sv]
// Other backplane nodes: their share of the wired-OR bad line
`timescale 1ns/10ps
`default_nettype none
module besl_far_nodes
(
  input wire logic node_bad_line_oe,
  input wire logic other_bad,
  output logic node_bad_line_in_n
);
  // Pull-up line, low while any node pulls it
  assign node_bad_line_in_n = ~(node_bad_line_oe | other_bad);
endmodule
`default_nettype wire

// [tb/bus_error_status_logger_tb_top.sv]
// Register-level testbench of the bus error status logger
`timescale 1ns/10ps
`default_nettype none
module bus_error_status_logger_tb_top;
  localparam int TO = 20;
  localparam int STM = 30;
  localparam logic [31:0] EVM [18] = '{32'h08000000, 32'h02000000, 32'h00800000,
    32'h00400000, 32'h00200000, 32'h00100000, 32'h00080000, 32'h00042000,
    32'h00010000, 32'h00008000, 32'h00001000, 32'h00020000, 32'h0, 32'h0, 32'h0,
    32'h01800000, 32'h00102000, 32'h0};
  logic clk = 1'b0, reset = 1'b1, dc_n = 1'b1, halt_en = 1'b1, other_bad = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, st_pass = 1'b0, cnf_ack = 1'b0, retry = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, cmd_addr = 32'h12345678, ext_info = 32'h9ABCDEF0;
  logic [14:0] ev = 15'h0;
  logic [3:0] seq_rx = 4'h5;
  logic [31:0] reg_rdata;
  logic reg_rvalid, bad_oe, bad_in_n, node_busy, halt_req, irq;
  int failures = 0;
  int samples_checked = 0;
  ////////////////////////////////////////////////////////////////////////////////
  besl_logger #(.TXN_TIMEOUT_CYC(TO), .SELFTEST_MAX_CYC(STM)) u_dut (.clk(clk),
    .reset(reset), .dc_low_line_n(dc_n), .node_bad_line_in_n(bad_in_n),
    .halt_enable(halt_en), .slot_id(4'hA), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .selftest_pass(st_pass),
    .txn_req(ev[12]), .txn_end(ev[13]), .txn_start(ev[14]), .txn_cmd_addr(cmd_addr),
    .txn_ext_info(ext_info), .ev_cnf_single(ev[0]), .ev_wei_implied_vector_intr(ev[1]),
    .ev_parity_err(ev[2]), .ev_cnf_ack(cnf_ack), .ev_csr_write_abort(ev[3]),
    .ev_read_data_noack(ev[4]), .ev_write_noack_final(ev[5]), .retry_enable(retry),
    .ev_crd_resp(ev[6]), .ev_no_read_reply(ev[7]), .seq_valid(ev[11]), .seq_rx(seq_rx),
    .seq_exp(4'h5), .ev_read_err_resp(ev[8]), .ev_cmd_noack_final(ev[9]),
    .ev_ext_lock(ev[10]), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .node_bad_line_o(), .node_bad_line_oe(bad_oe), .node_busy(node_busy),
    .halt_request(halt_req), .hard_err_irq(irq));
  besl_far_nodes u_far (.node_bad_line_oe(bad_oe), .other_bad(other_bad),
    .node_bad_line_in_n(bad_in_n));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic summarize();
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      failures++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // Data counts only in the single cycle that rvalid marks
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk($sformatf("reg_%h", a), (reg_rvalid === 1'b1) ? reg_rdata : 32'hBAD0BAD0, e);
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    ev[k == 15 ? 2 : k == 16 ? 5 : k == 17 ? 11 : k] = 1'b1;
    cnf_ack = (k == 15);
    retry = (k == 16);
    seq_rx = (k == 11) ? 4'h3 : 4'h5;
    @(negedge clk);
    ev = 15'h0;
    cnf_ack = 1'b0;
    retry = 1'b0;
    chk($sformatf("irq_%0d", k), {31'h0, irq}, {31'h0, k == 1});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Generous guard; a hang counts as a failure
    #2000000;
    failures++;
    summarize();
  end
  initial
  begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk("busy", {31'h0, node_busy}, 32'h1);
    chk("bad_oe", {31'h0, bad_oe}, 32'h1);
    rc(8'h04, 32'h90000CA0);
    rc(8'h40, 32'h0);
    wr(8'h04, 32'h0);
    rc(8'h04, 32'h90000CA0);
    @(negedge clk);
    st_pass = 1'b1;
    @(negedge clk);
    st_pass = 1'b0;
    repeat (4) @(negedge clk);
    chk("busy", {31'h0, node_busy}, 32'h0);
    chk("bad_oe", {31'h0, bad_oe}, 32'h0);
    wr(8'h04, 32'h00000C00);
    rc(8'h04, 32'h000000A0);
    other_bad = 1'b1;
    repeat (4) @(negedge clk);
    rc(8'h04, 32'h100000A0);
    other_bad = 1'b0;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 18; k++)
    begin
      if (k inside {[12:14]}) continue;
      pulse(k);
      rc(8'h04, (EVM[k] == 0) ? 32'hA0 : (32'h800000A0 | EVM[k]));
      if (k == 10) rc(8'h14, 32'h2);
      if (k == 10) wr(8'h14, 32'h2);
      else wr(8'h04, EVM[k]);
      rc(8'h04, 32'hA0);
    end
    pulse(12);
    repeat (TO / 2) @(negedge clk);
    pulse(13);
    repeat (TO + 5) @(negedge clk);
    rc(8'h04, 32'hA0);
    pulse(12);
    repeat (TO + 5) @(negedge clk);
    rc(8'h04, 32'h800020A0);
    wr(8'h04, 32'h00002000);
    pulse(14);
    rc(8'h08, 32'h12345678);
    rc(8'h2C, 32'h9ABCDEF0);
    cmd_addr = 32'h0F0F0F0F;
    ext_info = 32'h0000F00F;
    // Each locking flag in turn must freeze the log; the timeout flag is tried only together with no read reply
    foreach (EVM[k])
    begin
      if (!(k inside {5, 7, 8, 9, 10, 11})) continue;
      pulse(k);
      pulse(14);
      rc(8'h08, 32'h12345678);
      if (k == 10) wr(8'h14, 32'h2);
      else wr(8'h04, EVM[k]);
    end
    pulse(14);
    rc(8'h08, 32'h0F0F0F0F);
    rc(8'h2C, 32'h0000F00F);
    wr(8'h04, 32'h20000000);
    repeat (4) @(negedge clk);
    chk("halt", {31'h0, halt_req}, 32'h1);
    rc(8'h04, 32'h200000A0);
    halt_en = 1'b0;
    repeat (4) @(negedge clk);
    chk("halt", {31'h0, halt_req}, 32'h0);
    wr(8'h04, 32'h0);
    halt_en = 1'b1;
    wr(8'h04, 32'h40000000);
    repeat (3) @(negedge clk);
    chk("busy", {31'h0, node_busy}, 32'h1);
    rc(8'h04, 32'hD0000CA0);
    repeat (STM + 5) @(negedge clk);
    chk("busy", {31'h0, node_busy}, 32'h0);
    rc(8'h04, 32'hD0000CA0);
    dc_n = 1'b0;
    repeat (4) @(negedge clk);
    dc_n = 1'b1;
    repeat (5) @(negedge clk);
    rc(8'h04, 32'h90000CA0);
    summarize();
  end
endmodule
`default_nettype wire
